// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic       clk_i  = 1'b0;
   logic       srst_i = 1'b1;
   logic [7:0] addr_q = 8'h00;
   logic [7:0] wdata_q = 8'h00;
   logic [7:0] tio1_q = 8'h00;
   logic [7:0] tio2_q = 8'h00;
   logic       wr_q = 1'b0;
   logic       rd_q = 1'b0;
   logic       swr_q = 1'b0;
   logic       srd_q = 1'b0;
   logic [7:0] rdata_e;
   logic [7:0] rdata_s;
   logic       lpf, lim, sq, odd, pvld, subcarrier_sync_phase, odd_l;
   logic       pal_q = 1'b0;
   int         cnt_s, cnt_o, cnt_p;
   logic [7:0] pix;
   logic [3:0] lvl0;
   int         fail_count = 0;
   int         checked = 0;
   int         cnt_h;
   wire  [3:0] oe_e;
   wire  [3:0] oe_s;
   wire  [3:0] lvl;

   vtio_if vtio_if_inst ();
   assign oe_e = {vtio_if_inst.blank_enc_oe, vtio_if_inst.hsync_enc_oe, vtio_if_inst.vsync_enc_oe, vtio_if_inst.pclk_enc_oe};
   assign oe_s = {vtio_if_inst.blank_src_oe, vtio_if_inst.hsync_src_oe, vtio_if_inst.vsync_src_oe, vtio_if_inst.pclk_src_oe};
   assign lvl  = {vtio_if_inst.blank_w, vtio_if_inst.hsync_w, vtio_if_inst.vsync_w, vtio_if_inst.field_src};

   vtio_encoder vtio_encoder_inst (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_q), .wdata_i(wdata_q),
      .wr_i(wr_q), .rd_i(rd_q), .rdata_o(rdata_e), .pal_i(pal_q), .luma_lpf_o(lpf), .comp_limit_o(lim),
      .square_pixel_o(sq), .sch_reset_o(subcarrier_sync_phase), .odd_field_o(odd), .pixel_valid_o(pvld), .pixel_o(pix),
      .lnk(vtio_if_inst));
   vtio_source vtio_source_inst (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_q[3:0]), .wdata_i(wdata_q),
      .wr_i(swr_q), .rd_i(srd_q), .rdata_o(rdata_s), .tio1_i(tio1_q), .tio2_i(tio2_q), .lnk(vtio_if_inst));
   vtio_checker vtio_checker_inst (.clk_i(clk_i), .srst_i(srst_i),
      .blank_enc_oe(vtio_if_inst.blank_enc_oe), .blank_src_oe(vtio_if_inst.blank_src_oe),
      .hsync_enc_oe(vtio_if_inst.hsync_enc_oe), .hsync_src_oe(vtio_if_inst.hsync_src_oe),
      .vsync_enc_oe(vtio_if_inst.vsync_enc_oe), .vsync_src_oe(vtio_if_inst.vsync_src_oe),
      .pclk_enc_oe(vtio_if_inst.pclk_enc_oe), .pclk_src_oe(vtio_if_inst.pclk_src_oe),
      .pclk_enc_o(vtio_if_inst.pclk_enc_o));

   ////////////////////////////////////////////////////////////////////////////
   // Clock, compare and bus tasks
   initial begin
      forever #20 clk_i = ~clk_i;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Mirror lands with the write so the source never disagrees with the encoder
   task automatic wr(input logic src, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_q  <= a;
      wdata_q <= d;
      if (src) swr_q <= 1'b1;
      else wr_q <= 1'b1;
      @(posedge clk_i);
      swr_q <= 1'b0;
      wr_q  <= 1'b0;
      if (!src && a == 8'h04) tio1_q <= d & vtio_pkg::VTIO_MSK_TIO1;
      if (!src && a == 8'h05) tio2_q <= d & vtio_pkg::VTIO_MSK_TIO2;
   endtask : wr

   task automatic rdc(input logic src, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr_q <= a;
      if (src) srd_q <= 1'b1;
      else rd_q <= 1'b1;
      @(posedge clk_i);
      srd_q <= 1'b0;
      rd_q  <= 1'b0;
      #1;
      chk(src ? rdata_s : rdata_e, exp);
   endtask : rdc

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : idle

   task automatic count_hsync();
      cnt_h = 0;
      repeat (1800) begin
         @(posedge clk_i);
         cnt_h += int'(vtio_if_inst.hsync_w);
      end
   endtask : count_hsync

   // Counts phase resets, field flips and captured source pixels
   task automatic watch(input int n);
      cnt_s = 0;
      cnt_o = 0;
      cnt_p = 0;
      repeat (n) begin
         odd_l = odd;
         @(posedge clk_i);
         #1;
         cnt_s += int'(subcarrier_sync_phase);
         cnt_o += int'(odd != odd_l);
         cnt_p += int'(pvld && pix == 8'h3c);
      end
   endtask : watch

   task automatic report_and_stop();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the roughly 26.5k cycles of the tests
   initial begin
      #(40000 * 40);
      fail_count++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      rdc(1'b0, 8'h03, 8'ha0);
      rdc(1'b0, 8'h04, 8'h00);
      rdc(1'b0, 8'h05, 8'h00);
      rdc(1'b0, 8'h00, 8'h5a);
      rdc(1'b0, 8'h07, 8'h00);
      chk({7'h0, lpf}, 8'h01);
      wr(1'b0, 8'h03, 8'hff);
      rdc(1'b0, 8'h03, 8'he0);
      chk({6'h0, lpf, lim}, 8'h03);
      wr(1'b0, 8'h03, 8'h00);
      idle(2);
      chk({6'h0, lpf, lim}, 8'h00);
      wr(1'b0, 8'h05, 8'hff);
      rdc(1'b0, 8'h05, 8'h18);
      chk({7'h0, sq}, 8'h01);
      wr(1'b0, 8'h05, 8'h00);
      idle(2);
      chk({7'h0, sq}, 8'h00);
      wr(1'b0, 8'h04, 8'hff);
      rdc(1'b0, 8'h04, 8'hbf);
      // Source as timing master while the encoder takes every pin in
      wr(1'b0, 8'h04, 8'h00);
      wr(1'b1, {4'h0, vtio_pkg::VTIO_H_CTRL}, 8'h01);
      idle(3);
      chk({4'h0, oe_e}, 8'h00);
      chk({4'h0, oe_s}, 8'h0f);
      wr(1'b0, 8'h04, 8'h28);
      wr(1'b0, 8'h05, 8'h10);
      idle(3);
      chk({4'h0, oe_e}, 8'h0f);
      chk({4'h0, oe_s}, 8'h00);
      // Past the frame sync lines, then flip every polarity at once
      idle(14000);
      count_hsync();
      chk({7'h0, cnt_h > 900}, 8'h01);
      lvl0 = lvl;
      wr(1'b0, 8'h04, 8'h3f);
      idle(2);
      chk({4'h0, lvl}, {4'h0, ~lvl0});
      count_hsync();
      chk({7'h0, cnt_h > 900}, 8'h00);
      // Source master again on a short raster: 16 pixels, 8 lines, 256 clocks a field
      wr(1'b0, 8'h04, 8'h00);
      wr(1'b0, 8'h05, 8'h00);
      wr(1'b1, 8'h02, 8'h04);
      wr(1'b1, 8'h03, 8'h02);
      wr(1'b1, 8'h04, 8'h04);
      wr(1'b1, 8'h05, 8'h02);
      wr(1'b1, 8'h06, 8'h01);
      wr(1'b1, 8'h07, 8'h02);
      wr(1'b1, 8'h08, 8'h3c);
      wr(1'b0, 8'h03, 8'h20);
      idle(600);
      watch(4096);
      chk(8'(cnt_s), 8'h04);
      chk(8'(cnt_o), 8'h10);
      chk({7'h0, cnt_p > 0}, 8'h01);
      @(posedge clk_i);
      pal_q <= 1'b1;
      idle(2);
      watch(4096);
      chk(8'(cnt_s), 8'h02);
      report_and_stop();
   end
endmodule : testbench

// file: bench/vtio_checker.sv
`timescale 1ns/1ps
module vtio_checker (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic srst_i,
   // Pin enables of both ends
   input  wire logic blank_enc_oe,
   input  wire logic blank_src_oe,
   input  wire logic hsync_enc_oe,
   input  wire logic hsync_src_oe,
   input  wire logic vsync_enc_oe,
   input  wire logic vsync_src_oe,
   input  wire logic pclk_enc_oe,
   input  wire logic pclk_src_oe,
   // Pixel clock level from the encoder
   input  wire logic pclk_enc_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   ////////////////////////////////////////////////////////////////////////////
   // Direction: one driver per pin, syncs switch as a pair
   a_blank_one_drv: assert property (!(blank_enc_oe && blank_src_oe))
      else $error("blank pin driven by both ends");
   a_hsync_one_drv: assert property (!(hsync_enc_oe && hsync_src_oe))
      else $error("line sync pin driven by both ends");
   a_vsync_one_drv: assert property (!(vsync_enc_oe && vsync_src_oe))
      else $error("frame sync pin driven by both ends");
   a_pclk_one_drv: assert property (!(pclk_enc_oe && pclk_src_oe))
      else $error("pixel clock driven by both ends");
   a_sync_paired: assert property (hsync_enc_oe == vsync_enc_oe)
      else $error("sync directions differ");
   a_sync_rise_same: assert property ($rose(hsync_enc_oe) |-> $rose(vsync_enc_oe))
      else $error("sync outputs not enabled together");
   // Reset leaves the blank, line sync and pixel clock encoder pins inputs; a stale register would show here
   a_reset_inputs: assert property ($past(srst_i) |-> !blank_enc_oe && !hsync_enc_oe && !pclk_enc_oe)
      else $error("encoder drives a pin after reset");
   // Driven pixel clock is a one-cycle step level
   a_pclk_step: assert property (pclk_enc_oe && pclk_enc_o |=> !pclk_enc_o)
      else $error("pixel clock high two cycles");

   c_blank_out: cover property (blank_enc_oe);
   c_pclk_out: cover property (pclk_enc_oe && pclk_enc_o);
   c_sync_in: cover property (hsync_src_oe && vsync_src_oe);
endmodule : vtio_checker

// file: design/vtio_encoder.sv
`timescale 1ns/1ps
// Contract
// - Bit 7 enables luma lowpass filtering, reset one
// - Bit 6 clamps composite above half sync
// - Bit 5 resets subcarrier phase every 4/8 fields
// - Blank timing select ignored unless blank output
// - Select 0: first pixel one cycle after blank; the encoder takes it two pixels after blank falls at an input pin, two pixels after it rises at an output pin
// - Select 1: first pixel as blank deasserts; the encoder takes pixels while blank is asserted at the pin
// - Bit 5 sets blank strobe direction, reset input
// - Bit 4 sets blank strobe polarity
// - Bit 2 sets line sync polarity
// - Bit 1 sets frame sync polarity
// - Bit 0 sets field indicator polarity
// - Bit 4 sets pixel clock direction
// - Bit 3 selects square or rectangular pixels
// - Keep aspect bit zero for 656 input
module vtio_encoder #(
   parameter int W = 12
) (
   // Clock and reset
   input  wire logic   clk_i,
   input  wire logic   srst_i,
   // Register port
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   // Standard select: 1 for PAL field cadence
   input  wire logic       pal_i,
   // Video path state
   output logic            luma_lpf_o,
   output logic            comp_limit_o,
   output logic            square_pixel_o,
   output logic            sch_reset_o,
   output logic            odd_field_o,
   output logic            pixel_valid_o,
   output logic [7:0]      pixel_o,
   // Link
   vtio_if.enc             lnk
);
   parameter logic [7:0] PRODUCT_CODE = 8'h5a; // Arbitrary identification value

   logic [7:0] vproc_q, tio1_q, tio2_q, rdata_q;
   logic       luma_q, comp_q, sq_q, sch_q, odd_out_q, pv_q;
   logic [7:0] pix_q;
   logic [3:0] fcnt_q;
   logic [3:0] pdiv_q;
   logic       pclk_q;
   logic       blank_prev_q, blank_dly_q;
   logic       hs_oq, vs_oq, bl_oq, pclk_oe_q, bl_oe_q, sy_oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire sel_vproc = addr_i == vtio_pkg::VTIO_OFS_VPROC;
   wire sel_tio1  = addr_i == vtio_pkg::VTIO_OFS_TIO1;
   wire sel_tio2  = addr_i == vtio_pkg::VTIO_OFS_TIO2;
   wire sel_id    = addr_i == vtio_pkg::VTIO_OFS_ID;
   wire [7:0] rd_mux = sel_vproc ? vproc_q :
                       sel_tio1  ? tio1_q  :
                       sel_tio2  ? tio2_q  :
                       sel_id    ? PRODUCT_CODE : 8'h00;

   // Writes store only defined bits so reserved ones stay zero
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         vproc_q <= vtio_pkg::VTIO_RST_VPROC;
         tio1_q  <= vtio_pkg::VTIO_RST_TIO1;
         tio2_q  <= vtio_pkg::VTIO_RST_TIO2;
         rdata_q <= 8'h00;
      end else begin
         if (wr_i && sel_vproc) vproc_q <= wdata_i & vtio_pkg::VTIO_MSK_VPROC;
         if (wr_i && sel_tio1)  tio1_q  <= wdata_i & vtio_pkg::VTIO_MSK_TIO1;
         if (wr_i && sel_tio2)  tio2_q  <= wdata_i & vtio_pkg::VTIO_MSK_TIO2;
         rdata_q <= rd_i ? rd_mux : 8'h00;
      end
   end
   assign rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Field decode of the control registers
   wire blank_out = tio1_q[vtio_pkg::VTIO_B_BLANK_OUT];
   wire sync_out  = tio1_q[vtio_pkg::VTIO_B_SYNC_OUT];
   wire pclk_out  = tio2_q[vtio_pkg::VTIO_B_PCLK_OUT];
   wire tsel      = blank_out & tio1_q[vtio_pkg::VTIO_B_BLANK_TSEL];
   wire bpol      = tio1_q[vtio_pkg::VTIO_B_BLANK_POL];
   wire hpol      = tio1_q[vtio_pkg::VTIO_B_HSYNC_POL];
   wire vpol      = tio1_q[vtio_pkg::VTIO_B_VSYNC_POL];
   wire fpol      = tio1_q[vtio_pkg::VTIO_B_FIELD_POL];

   ////////////////////////////////////////////////////////////////////////////
   // Pixel clock: divided enable, driven out only when master
   wire pdiv_wrap = pdiv_q >= vtio_pkg::VTIO_PCLK_DIV - 4'h1;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pdiv_q <= 4'h0;
         pclk_q <= 1'b0;
      end else begin
         pdiv_q <= pdiv_wrap ? 4'h0 : pdiv_q + 4'h1;
         pclk_q <= pdiv_wrap;
      end
   end
   // Pixel step: own enable as master, incoming clock level as slave
   wire pstep = pclk_out ? pdiv_wrap : lnk.pclk_w;

   ////////////////////////////////////////////////////////////////////////////
   // Internal timing master used when strobes are outputs
   logic r_hs, r_vs, r_bl, r_odd, r_fend;
   vtio_raster #(.W(W)) u_raster (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .step_i      (pstep),
      .htot_i      (vtio_pkg::VTIO_DEF_HTOT),
      .hsw_i       (vtio_pkg::VTIO_DEF_HSW),
      .hbl_i       (vtio_pkg::VTIO_DEF_HBL),
      .vtot_i      (vtio_pkg::VTIO_DEF_VTOT),
      .vsw_i       (vtio_pkg::VTIO_DEF_VSW),
      .vbl_i       (vtio_pkg::VTIO_DEF_VBL),
      .hsync_o     (r_hs),
      .vsync_o     (r_vs),
      .blank_o     (r_bl),
      .odd_o       (r_odd),
      .field_end_o (r_fend)
   );

   // Incoming levels decoded to true sense by the polarity bits
   wire in_bl = lnk.blank_w ~^ bpol;
   wire in_vs = lnk.vsync_w ~^ vpol;
   wire blank_now = blank_out ? r_bl : in_bl;

   // Slave field end: leading edge of incoming frame sync
   logic vs_prev_q;
   wire  fend = sync_out ? r_fend : (pstep && in_vs && !vs_prev_q);

   ////////////////////////////////////////////////////////////////////////////
   // Strobe pins: registered levels and enables, polarity applied
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hs_oq <= 1'b0; vs_oq <= 1'b0; bl_oq <= 1'b0;
         bl_oe_q <= 1'b0; sy_oe_q <= 1'b0; pclk_oe_q <= 1'b0;
      end else begin
         hs_oq     <= r_hs ~^ hpol;
         vs_oq     <= r_vs ~^ vpol;
         bl_oq     <= r_bl ~^ bpol;
         bl_oe_q   <= blank_out;
         sy_oe_q   <= sync_out;
         pclk_oe_q <= pclk_out;
      end
   end
   assign lnk.blank_enc_o  = bl_oq;
   assign lnk.blank_enc_oe = bl_oe_q;
   assign lnk.hsync_enc_o  = hs_oq;
   assign lnk.hsync_enc_oe = sy_oe_q;
   assign lnk.vsync_enc_o  = vs_oq;
   assign lnk.vsync_enc_oe = sy_oe_q;
   assign lnk.pclk_enc_o   = pclk_q;
   assign lnk.pclk_enc_oe  = pclk_oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pixel capture. Pin blank lags the raster by one clock and pin_bl inverts it when blank is an output; select 1
   // takes data while blank is asserted at the pin, select 0 two pixels later, or two pixels after blank falls as an input.
   wire pin_bl    = blank_out ? !(bl_oq ~^ bpol) : blank_now;
   wire take_now  = !pin_bl;
   wire take_late = !blank_dly_q;
   wire take      = pstep && (tsel ? take_now : take_late);

   // Field count for the periodic phase reset; reset when disabled
   wire [3:0] fper = pal_i ? vtio_pkg::VTIO_SCH_FIELDS_PAL : vtio_pkg::VTIO_SCH_FIELDS_NTSC;
   wire       sch_en = vproc_q[vtio_pkg::VTIO_B_SCH_RESET];
   wire       field_odd = sync_out ? r_odd : (lnk.field_src ~^ fpol);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         blank_dly_q <= 1'b1; blank_prev_q <= 1'b1; vs_prev_q <= 1'b0;
         pv_q <= 1'b0; pix_q <= 8'h00; fcnt_q <= 4'h0; sch_q <= 1'b0;
         luma_q <= 1'b1; comp_q <= 1'b0; sq_q <= 1'b0; odd_out_q <= 1'b0;
      end else begin
         if (pstep) begin
            blank_prev_q <= pin_bl;
            blank_dly_q  <= blank_prev_q;
            vs_prev_q    <= in_vs;
         end
         pv_q  <= take;
         if (take) pix_q <= lnk.pixel;
         sch_q <= 1'b0;
         if (!sch_en) begin
            fcnt_q <= 4'h0;
         end else if (fend) begin
            fcnt_q <= (fcnt_q >= fper - 4'h1) ? 4'h0 : fcnt_q + 4'h1;
            sch_q  <= fcnt_q >= fper - 4'h1;
         end
         luma_q    <= vproc_q[vtio_pkg::VTIO_B_LUMA_LPF];
         comp_q    <= vproc_q[vtio_pkg::VTIO_B_COMP_LIMIT];
         sq_q      <= tio2_q[vtio_pkg::VTIO_B_ASPECT_SQ];
         odd_out_q <= field_odd;
      end
   end

   // Video path controls
   assign luma_lpf_o     = luma_q;
   assign comp_limit_o   = comp_q;
   assign square_pixel_o = sq_q;
   assign sch_reset_o    = sch_q;
   assign odd_field_o    = odd_out_q;
   assign pixel_valid_o  = pv_q;
   assign pixel_o        = pix_q;
endmodule : vtio_encoder

// file: design/vtio_raster.sv
`timescale 1ns/1ps
// Raster counter shared by both ends: produces active-high timing levels
module vtio_raster #(
   parameter int W = 12
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         srst_i,
   // Control
   input  wire logic         step_i,
   input  wire logic [W-1:0] htot_i,
   input  wire logic [W-1:0] hsw_i,
   input  wire logic [W-1:0] hbl_i,
   input  wire logic [W-1:0] vtot_i,
   input  wire logic [W-1:0] vsw_i,
   input  wire logic [W-1:0] vbl_i,
   // Timing levels, true sense
   output logic              hsync_o,
   output logic              vsync_o,
   output logic              blank_o,
   output logic              odd_o,
   output logic              field_end_o
);
   logic [W-1:0] hcnt_q;
   logic [W-1:0] vcnt_q;
   logic         odd_q;
   wire          line_end  = (hcnt_q >= htot_i - W'(1));
   wire          frame_end = line_end && (vcnt_q >= vtot_i - W'(1));

   ////////////////////////////////////////////////////////////////////////////
   // Counters advance only on the pixel enable
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hcnt_q <= '0;
         vcnt_q <= '0;
         odd_q  <= 1'b1;
      end else if (step_i) begin
         hcnt_q <= line_end ? '0 : hcnt_q + W'(1);
         if (line_end) begin
            vcnt_q <= frame_end ? '0 : vcnt_q + W'(1);
         end
         if (frame_end) begin
            odd_q <= ~odd_q;
         end
      end
   end

   // Decoded levels; each field is treated as one raster pass
   assign hsync_o     = hcnt_q < hsw_i;
   assign vsync_o     = vcnt_q < vsw_i;
   assign blank_o     = (hcnt_q < hbl_i) || (vcnt_q < vbl_i);
   assign odd_o       = odd_q;
   assign field_end_o = step_i && frame_end;
endmodule : vtio_raster

// file: design/vtio_source.sv
`timescale 1ns/1ps
// Pixel source: timing master or slave mirroring the encoder's settings
module vtio_source #(
   parameter int W = 12
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   // Command port
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   // Mirror of the encoder timing pin controls
   input  wire logic [7:0] tio1_i,
   input  wire logic [7:0] tio2_i,
   // Link
   vtio_if.src             lnk
);
   logic [7:0]   ctrl_q, pix_q, rdata_q, dout_q;
   logic [W-1:0] htot_q, hsw_q, hbl_q, vtot_q, vsw_q, vbl_q;
   logic [3:0]   pdiv_q;
   logic         pclk_q, hs_q, vs_q, bl_q, fld_q, oe_bl_q, oe_sy_q, oe_pc_q;
   logic         bl_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Command registers
   wire en = ctrl_q[vtio_pkg::VTIO_C_ENABLE];
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl_q <= 8'h00; pix_q <= 8'h00;
         htot_q <= vtio_pkg::VTIO_DEF_HTOT; hsw_q <= vtio_pkg::VTIO_DEF_HSW;
         hbl_q  <= vtio_pkg::VTIO_DEF_HBL;  vtot_q <= vtio_pkg::VTIO_DEF_VTOT;
         vsw_q  <= vtio_pkg::VTIO_DEF_VSW;  vbl_q  <= vtio_pkg::VTIO_DEF_VBL;
      end else if (wr_i) begin
         unique case (addr_i)
            vtio_pkg::VTIO_H_CTRL:  ctrl_q <= wdata_i;
            vtio_pkg::VTIO_H_HTOT:  htot_q <= W'(wdata_i) << 2;
            vtio_pkg::VTIO_H_HSW:   hsw_q  <= W'(wdata_i);
            vtio_pkg::VTIO_H_HBL:   hbl_q  <= W'(wdata_i);
            vtio_pkg::VTIO_H_VTOT:  vtot_q <= W'(wdata_i) << 2;
            vtio_pkg::VTIO_H_VSW:   vsw_q  <= W'(wdata_i);
            vtio_pkg::VTIO_H_VBL:   vbl_q  <= W'(wdata_i);
            vtio_pkg::VTIO_H_PIXEL: pix_q  <= wdata_i;
            default: ;
         endcase
      end
   end

   wire [7:0] rd_mux = (addr_i == vtio_pkg::VTIO_H_CTRL)   ? ctrl_q :
                       (addr_i == vtio_pkg::VTIO_H_STATUS) ? {4'h0, fld_q, lnk.vsync_w, lnk.hsync_w, lnk.blank_w} :
                       (addr_i == vtio_pkg::VTIO_H_PIXEL)  ? pix_q : 8'h00;
   always_ff @(posedge clk_i) begin
      if (srst_i) rdata_q <= 8'h00;
      else        rdata_q <= rd_i ? rd_mux : 8'h00;
   end
   assign rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Direction and polarity from the mirrored encoder controls
   wire enc_bl   = tio1_i[vtio_pkg::VTIO_B_BLANK_OUT];
   wire enc_sy   = tio1_i[vtio_pkg::VTIO_B_SYNC_OUT];
   wire enc_pc   = tio2_i[vtio_pkg::VTIO_B_PCLK_OUT];
   wire tsel     = enc_bl & tio1_i[vtio_pkg::VTIO_B_BLANK_TSEL];
   wire bpol     = tio1_i[vtio_pkg::VTIO_B_BLANK_POL];
   wire hpol     = tio1_i[vtio_pkg::VTIO_B_HSYNC_POL];
   wire vpol     = tio1_i[vtio_pkg::VTIO_B_VSYNC_POL];
   wire fpol     = tio1_i[vtio_pkg::VTIO_B_FIELD_POL];

   // Pixel enable: own divider, or the encoder's clock when it drives
   wire pdiv_wrap = pdiv_q >= vtio_pkg::VTIO_PCLK_DIV - 4'h1;
   wire pstep     = enc_pc ? lnk.pclk_w : pdiv_wrap;

   logic r_hs, r_vs, r_bl, r_odd;
   vtio_raster #(.W(W)) u_raster (
      .clk_i       (clk_i),
      .srst_i      (srst_i | ~en),
      .step_i      (pstep),
      .htot_i      (htot_q),
      .hsw_i       (hsw_q),
      .hbl_i       (hbl_q),
      .vtot_i      (vtot_q),
      .vsw_i       (vsw_q),
      .vbl_i       (vbl_q),
      .hsync_o     (r_hs),
      .vsync_o     (r_vs),
      .blank_o     (r_bl),
      .odd_o       (r_odd),
      .field_end_o ()
   );

   // Blank in true sense, from the pin when the encoder drives it, else the raster; then pixel timing per select
   wire in_bl = enc_bl ? (lnk.blank_w ~^ bpol) : r_bl;
   wire show  = tsel ? !in_bl : !bl_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Registered pins
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pdiv_q <= 4'h0; pclk_q <= 1'b0; hs_q <= 1'b0; vs_q <= 1'b0; bl_q <= 1'b0;
         fld_q <= 1'b0; oe_bl_q <= 1'b0; oe_sy_q <= 1'b0; oe_pc_q <= 1'b0;
         bl_prev_q <= 1'b1; dout_q <= 8'h00;
      end else begin
         pdiv_q  <= pdiv_wrap ? 4'h0 : pdiv_q + 4'h1;
         pclk_q  <= pdiv_wrap;
         hs_q    <= r_hs ~^ hpol;
         vs_q    <= r_vs ~^ vpol;
         bl_q    <= r_bl ~^ bpol;
         fld_q   <= r_odd ~^ fpol;
         oe_bl_q <= en & ~enc_bl;
         oe_sy_q <= en & ~enc_sy;
         oe_pc_q <= en & ~enc_pc;
         if (pstep) bl_prev_q <= in_bl;
         dout_q  <= show ? pix_q : 8'h00;
      end
   end

   assign lnk.blank_src_o  = bl_q;
   assign lnk.blank_src_oe = oe_bl_q;
   assign lnk.hsync_src_o  = hs_q;
   assign lnk.hsync_src_oe = oe_sy_q;
   assign lnk.vsync_src_o  = vs_q;
   assign lnk.vsync_src_oe = oe_sy_q;
   assign lnk.pclk_src_o   = pclk_q;
   assign lnk.pclk_src_oe  = oe_pc_q;
   assign lnk.field_src    = fld_q;
   assign lnk.pixel        = dout_q;
endmodule : vtio_source

// file: inc/vtio_if.sv
`timescale 1ns/1ps
interface vtio_if;
   // Timing strobes: per pin, a level from each end plus each end's enable; field and pixel come from the source only
   logic       blank_enc_o, blank_enc_oe, blank_src_o, blank_src_oe;
   logic       hsync_enc_o, hsync_enc_oe, hsync_src_o, hsync_src_oe;
   logic       vsync_enc_o, vsync_enc_oe, vsync_src_o, vsync_src_oe;
   logic       pclk_enc_o, pclk_enc_oe, pclk_src_o, pclk_src_oe;
   logic       field_src;
   logic [7:0] pixel;

   // Resolved pin levels: the end that enables wins, otherwise idle low
   logic blank_w, hsync_w, vsync_w, pclk_w;
   assign blank_w = blank_enc_oe ? blank_enc_o : (blank_src_oe ? blank_src_o : 1'b0);
   assign hsync_w = hsync_enc_oe ? hsync_enc_o : (hsync_src_oe ? hsync_src_o : 1'b0);
   assign vsync_w = vsync_enc_oe ? vsync_enc_o : (vsync_src_oe ? vsync_src_o : 1'b0);
   assign pclk_w  = pclk_enc_oe ? pclk_enc_o : (pclk_src_oe ? pclk_src_o : 1'b0);

   modport enc (
      output blank_enc_o, blank_enc_oe, hsync_enc_o, hsync_enc_oe,
      output vsync_enc_o, vsync_enc_oe, pclk_enc_o, pclk_enc_oe,
      input  blank_w, hsync_w, vsync_w, pclk_w, field_src, pixel
   );
   modport src (
      output blank_src_o, blank_src_oe, hsync_src_o, hsync_src_oe,
      output vsync_src_o, vsync_src_oe, pclk_src_o, pclk_src_oe,
      output field_src, pixel,
      input  blank_w, hsync_w, vsync_w, pclk_w
   );
endinterface : vtio_if

// file: inc/vtio_pkg.sv
package vtio_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] VTIO_OFS_VPROC = 8'h03;
   localparam logic [7:0] VTIO_OFS_TIO1  = 8'h04;
   localparam logic [7:0] VTIO_OFS_TIO2  = 8'h05;
   localparam logic [7:0] VTIO_OFS_ID    = 8'h00;

   // Reset values
   localparam logic [7:0] VTIO_RST_VPROC = 8'ha0;
   localparam logic [7:0] VTIO_RST_TIO1  = 8'h00;
   localparam logic [7:0] VTIO_RST_TIO2  = 8'h00;

   // Writable bit masks; reserved bits stay zero
   localparam logic [7:0] VTIO_MSK_VPROC = 8'he0;
   localparam logic [7:0] VTIO_MSK_TIO1  = 8'hbf;
   localparam logic [7:0] VTIO_MSK_TIO2  = 8'h18;

   // Video processing fields
   localparam int VTIO_B_LUMA_LPF   = 7;
   localparam int VTIO_B_COMP_LIMIT = 6;
   localparam int VTIO_B_SCH_RESET  = 5;

   // Timing pin control one fields
   localparam int VTIO_B_BLANK_TSEL = 7;
   localparam int VTIO_B_BLANK_OUT  = 5;
   localparam int VTIO_B_BLANK_POL  = 4;
   localparam int VTIO_B_SYNC_OUT   = 3;
   localparam int VTIO_B_HSYNC_POL  = 2;
   localparam int VTIO_B_VSYNC_POL  = 1;
   localparam int VTIO_B_FIELD_POL  = 0;

   // Timing pin control two fields
   localparam int VTIO_B_PCLK_OUT   = 4;
   localparam int VTIO_B_ASPECT_SQ  = 3;

   // Phase reset period in fields
   localparam logic [3:0] VTIO_SCH_FIELDS_NTSC = 4'h4;
   localparam logic [3:0] VTIO_SCH_FIELDS_PAL  = 4'h8;

   // Host command port offsets (host side registers)
   localparam logic [3:0] VTIO_H_CTRL   = 4'h0;
   localparam logic [3:0] VTIO_H_STATUS = 4'h1;
   localparam logic [3:0] VTIO_H_HTOT   = 4'h2;
   localparam logic [3:0] VTIO_H_HSW    = 4'h3;
   localparam logic [3:0] VTIO_H_HBL    = 4'h4;
   localparam logic [3:0] VTIO_H_VTOT   = 4'h5;
   localparam logic [3:0] VTIO_H_VSW    = 4'h6;
   localparam logic [3:0] VTIO_H_VBL    = 4'h7;
   localparam logic [3:0] VTIO_H_PIXEL  = 4'h8;

   // Host control bits
   localparam int VTIO_C_ENABLE = 0;

   // Default raster sizes in pixel clocks and lines
   localparam logic [11:0] VTIO_DEF_HTOT = 12'h35a;
   localparam logic [11:0] VTIO_DEF_HSW  = 12'h040;
   localparam logic [11:0] VTIO_DEF_HBL  = 12'h08a;
   localparam logic [11:0] VTIO_DEF_VTOT = 12'h20d;
   localparam logic [11:0] VTIO_DEF_VSW  = 12'h006;
   localparam logic [11:0] VTIO_DEF_VBL  = 12'h028;

   // Pixel clock divider: one pixel enable every two system clocks
   localparam logic [3:0] VTIO_PCLK_DIV = 4'h2;

endpackage : vtio_pkg
